// ==== shared/sdpi_pkg.sv ====
// Package of constants and carrier types for the memory pin interface
package sdpi_pkg;
    // Bus widths
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int LANES = 4;
    localparam int RANKS = 4;
    // Clock multiplier choices
    localparam logic [1:0] MULT_2X = 2'h2;
    localparam logic [1:0] MULT_3X = 2'h3;
    // Reset values of pins
    localparam logic [RANKS-1:0] SEL_IDLE = 4'hf;
    localparam logic [LANES-1:0] MASK_ALL = 4'hf;
    // Command codes: {ras_n, cas_n, we_n}
    localparam logic [2:0] CODE_NOP = 3'h7;
    localparam logic [2:0] CODE_ACT = 3'h3;
    localparam logic [2:0] CODE_RD = 3'h5;
    localparam logic [2:0] CODE_WR = 3'h4;
    localparam logic [2:0] CODE_PRE = 3'h2;
    localparam logic [2:0] CODE_REF = 3'h1;
    localparam logic [2:0] CODE_MRS = 3'h0;
    localparam logic [2:0] CODE_BST = 3'h6;

    // Memory commands requested by the controller core
    typedef enum logic [2:0] {
        SDPI_NOP, SDPI_ACT, SDPI_RD, SDPI_WR,
        SDPI_PRE, SDPI_REF, SDPI_MRS, SDPI_BST
    } sdpi_cmd_t;

    // One request from the core, taken on a memory clock edge
    typedef struct packed {
        sdpi_cmd_t cmd;
        logic [1:0] rank;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [3:0] rank_addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0] wmask;
    } sdpi_req_t;

    // Command pins bundled
    typedef struct packed {
        logic [RANKS-1:0] sel_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
    } sdpi_pins_t;
endpackage

// ==== logic/sdpi_clkgen.sv ====
// Memory clock generator: enable high every main clock, level toggling each main clock at either multiplier
`timescale 1ns/1ps
module sdpi_clkgen
    import sdpi_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Multiplier choice, static while running
    input wire logic [1:0] mult,
    // Enable held high, marking every main clock edge
    output logic mem_edge,
    // Memory clock level
    output logic mem_clk_r
);
    logic [1:0] phase_r; // Position within a run of mult main clocks

    // Count phases; wrap at the multiplier minus one
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase_r <= 2'h0;
        end else if (phase_r >= mult - 2'h1) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Edge pulse each phase; the fast clock is modelled as an enable
    assign mem_edge = 1'b1;

    // Level of the emitted clock, toggling each enable
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mem_clk_r <= 1'b0;
        end else begin
            mem_clk_r <= ~mem_clk_r;
        end
    end
endmodule

// ==== logic/sdpi_top.sv ====
// Pin side of the synchronous DRAM interface
// Functional notes
// - Memory clock at half the input, either multiplier
// - Two identical memory clock outputs
// - Row and column share 14-bit address
// - 32-bit data bus, 16-bit option
// - Two identical clock-enable outputs
// - One active-low select per rank
// - Selects become address for 256-Mbit parts
// - Row, column, write strobes active low
// - Four byte masks, one per lane
// - Idle under reset, start on release
`timescale 1ns/1ps
module sdpi_top
    import sdpi_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Static configuration
    input wire logic mult_3x,
    input wire logic half_width,
    input wire logic big_parts,
    // Request from core
    input wire logic req_valid,
    output logic req_ready,
    input wire sdpi_req_t req,
    // Read data to core
    output logic rd_valid_r,
    output logic [DW-1:0] rd_data_r,
    // Memory clocks and enables
    output logic mem_clock_out_a,
    output logic mem_clock_out_b,
    output logic mem_clock_enable_a,
    output logic mem_clock_enable_b,
    // Command pins
    output logic rank0_select_n,
    output logic rank1_select_n,
    output logic rank2_select_n,
    output logic rank3_select_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic write_strobe_n,
    output logic [AW-1:0] mem_row_col_address,
    // Byte masks
    output logic byte_mask_lane0,
    output logic byte_mask_lane1,
    output logic byte_mask_lane2,
    output logic byte_mask_lane3,
    // Data bus as three signals
    input wire logic [DW-1:0] mem_data_in,
    output logic [DW-1:0] mem_data_out_r,
    output logic [DW-1:0] mem_data_oe_r
);
    // Boot states after reset release
    typedef enum logic [1:0] {ST_RESET, ST_BOOT, ST_RUN} sdpi_state_t;

    sdpi_state_t state_r; // Interface phase
    logic mem_edge; // Memory clock enable pulse
    logic mem_clk; // Memory clock level
    sdpi_pins_t pins_r; // Registered command pins
    logic cke_r; // Shared clock enable level
    logic [LANES-1:0] mask_r; // Registered byte masks
    logic [1:0] mult; // Selected multiplier
    // Edges from a read's take until its data sits in the second sync
    // stage: command launch, memory answer, then the two sync flops
    localparam int RD_STAGES = 4;
    logic [RD_STAGES-1:0] rd_pend_r; // Reads in flight, one bit a cycle
    logic [DW-1:0] din_s1_r; // Data pin sync stage one
    logic [DW-1:0] din_s2_r; // Data pin sync stage two

    // Map a command to its strobe code
    function automatic logic [2:0] cmd_code(input sdpi_cmd_t c);
        case (c)
            SDPI_ACT: cmd_code = CODE_ACT;
            SDPI_RD: cmd_code = CODE_RD;
            SDPI_WR: cmd_code = CODE_WR;
            SDPI_PRE: cmd_code = CODE_PRE;
            SDPI_REF: cmd_code = CODE_REF;
            SDPI_MRS: cmd_code = CODE_MRS;
            SDPI_BST: cmd_code = CODE_BST;
            default: cmd_code = CODE_NOP;
        endcase
    endfunction

    // Pick the multiplier
    assign mult = mult_3x ? MULT_3X : MULT_2X;

    // Memory clock generator
    sdpi_clkgen u_clk (
        .clock(clock),
        .nrst(nrst),
        .mult(mult),
        .mem_edge(mem_edge),
        .mem_clk_r(mem_clk)
    );

    // Both clock pins carry one waveform
    assign mem_clock_out_a = mem_clk;
    assign mem_clock_out_b = mem_clk;

    // Boot sequence after reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RESET;
        end else begin
            case (state_r)
                ST_RESET: state_r <= ST_BOOT;
                ST_BOOT: state_r <= ST_RUN;
                ST_RUN: state_r <= ST_RUN;
                default: state_r <= ST_RESET;
            endcase
        end
    end

    // Requests taken only when running, on a memory edge
    assign req_ready = (state_r == ST_RUN) && mem_edge;

    // Clock enable rises one cycle after boot starts, as run starts
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cke_r <= 1'b0;
        end else begin
            cke_r <= (state_r != ST_RESET);
        end
    end
    assign mem_clock_enable_a = cke_r;
    assign mem_clock_enable_b = cke_r;

    // Command, select and address pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins_r <= '{sel_n: SEL_IDLE, ras_n: 1'b1, cas_n: 1'b1,
                        we_n: 1'b1, addr: '0};
        end else if (req_valid && req_ready) begin
            // Strobes low per command code
            {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} <=
                cmd_code(req.cmd);
            // Row on activate, column otherwise
            pins_r.addr <= (req.cmd == SDPI_ACT) ? req.row
                                                 : req.col;
            if (big_parts) begin
                pins_r.sel_n <= req.rank_addr;
            end else begin
                pins_r.sel_n <= ~(4'h1 << req.rank);
            end
        end else if (mem_edge) begin
            // No operation: deselect all ranks
            {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} <= CODE_NOP;
            pins_r.sel_n <= SEL_IDLE;
        end
    end

    assign rank0_select_n = pins_r.sel_n[0];
    assign rank1_select_n = pins_r.sel_n[1];
    assign rank2_select_n = pins_r.sel_n[2];
    assign rank3_select_n = pins_r.sel_n[3];
    assign row_strobe_n = pins_r.ras_n;
    assign column_strobe_n = pins_r.cas_n;
    assign write_strobe_n = pins_r.we_n;
    assign mem_row_col_address = pins_r.addr;

    // Write data, drive enables and byte masks
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mem_data_out_r <= '0;
            mem_data_oe_r <= '0;
            mask_r <= MASK_ALL;
        end else if (req_valid && req_ready && req.cmd == SDPI_WR) begin
            mem_data_out_r <= req.wdata;
            // Upper half stays undriven in narrow mode
            mem_data_oe_r <= half_width ? {{HALF_W{1'b0}}, {HALF_W{1'b1}}}
                                        : '1;
            mask_r <= half_width ? (req.wmask | 4'hc)
                                 : req.wmask;
        end else if (mem_edge) begin
            mem_data_oe_r <= '0;
            mask_r <= (req_valid && req_ready && req.cmd == SDPI_RD)
                      ? (half_width ? 4'hc : 4'h0) : MASK_ALL;
        end
    end
    assign byte_mask_lane0 = mask_r[0];
    assign byte_mask_lane1 = mask_r[1];
    assign byte_mask_lane2 = mask_r[2];
    assign byte_mask_lane3 = mask_r[3];

    // Synchronise the data pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= mem_data_in;
            din_s2_r <= din_s1_r;
        end
    end

    // Track issued reads until their data has crossed the sync stages;
    // capturing earlier would take whatever the bus held before the read
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_pend_r <= '0;
        end else begin
            rd_pend_r <= {rd_pend_r[RD_STAGES-2:0],
                          req_valid && req_ready && req.cmd == SDPI_RD};
        end
    end

    // Capture read data, zero-extending the narrow bus
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            rd_valid_r <= rd_pend_r[RD_STAGES-1];
            if (rd_pend_r[RD_STAGES-1]) begin
                rd_data_r <= half_width
                    ? {{HALF_W{1'b0}}, din_s2_r[HALF_W-1:0]}
                    : din_s2_r;
            end
        end
    end
endmodule

// ==== tb/sdpi_chk.sv ====
// Pin timing checker for the memory pin interface
`timescale 1ns/1ps
module sdpi_chk
    import sdpi_pkg::*;
#(parameter int AW = ADDR_W, parameter int DW = DATA_W) (
    // Clock, reset and configuration
    input wire logic clock, nrst, half_width, big_parts,
    // Request side
    input wire logic req_valid, req_ready,
    input wire sdpi_req_t req,
    // Memory pins
    input wire logic mem_clock_out_a, mem_clock_out_b,
    input wire logic mem_clock_enable_a, mem_clock_enable_b,
    input wire logic rank0_select_n, rank1_select_n, rank2_select_n,
    input wire logic rank3_select_n, row_strobe_n, column_strobe_n,
    input wire logic write_strobe_n, byte_mask_lane2, byte_mask_lane3,
    input wire logic [AW-1:0] mem_row_col_address,
    input wire logic [DW-1:0] mem_data_oe_r
);
    // Bundled selects, strobe code and the take strobe
    wire [3:0] sel = {rank3_select_n, rank2_select_n, rank1_select_n,
                      rank0_select_n};
    wire [2:0] pins = {row_strobe_n, column_strobe_n, write_strobe_n};
    wire take = req_valid && req_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_CLK_PAIR: assert property (
        mem_clock_out_a == mem_clock_out_b)
        else $error("memory clock outputs differ");
    AST_CKE_PAIR: assert property (
        mem_clock_enable_a == mem_clock_enable_b)
        else $error("clock enable outputs differ");
    AST_CLK_RUN: assert property ($past(nrst) |->
        mem_clock_out_a != $past(mem_clock_out_a))
        else $error("memory clock did not toggle");
    AST_RESET_IDLE: assert property (disable iff (1'b0) !nrst |->
        sel == SEL_IDLE && !mem_clock_enable_a && mem_data_oe_r == '0)
        else $error("pins not idle under reset");
    AST_CKE_UP: assert property (nrst [*3] |-> mem_clock_enable_a)
        else $error("clock enable late after reset");
    AST_ACT_ROW: assert property (take && req.cmd == SDPI_ACT |=>
        pins == CODE_ACT && mem_row_col_address == $past(req.row))
        else $error("activate pins or row wrong");
    AST_WR_COL: assert property (take && req.cmd == SDPI_WR |=>
        pins == CODE_WR && mem_row_col_address == $past(req.col))
        else $error("write pins or column wrong");
    AST_ONE_RANK: assert property (take && !big_parts |=>
        sel == ~(4'h1 << $past(req.rank)))
        else $error("wrong rank selected");
    AST_NOP_GAP: assert property (!take && !big_parts |=>
        sel == SEL_IDLE && pins == CODE_NOP)
        else $error("command held without request");
    AST_HALF: assert property (half_width && $past(half_width) |->
        byte_mask_lane2 && byte_mask_lane3 && mem_data_oe_r[DW-1:16] == '0)
        else $error("upper lanes active in half width");
endmodule
bind sdpi_top sdpi_chk #(.AW(AW), .DW(DW)) chk (.*);

// ==== tb/sdpi_mem_model.sv ====
// Memory ranks model: keeps one word, returns it after a read
`timescale 1ns/1ps
module sdpi_mem_model
    import sdpi_pkg::*;
(
    // Clock and command pins
    input wire logic clock, row_strobe_n, column_strobe_n, write_strobe_n,
    input wire logic rank0_select_n, rank1_select_n,
    input wire logic rank2_select_n, rank3_select_n,
    // Byte masks and write data
    input wire logic byte_mask_lane0, byte_mask_lane1,
    input wire logic byte_mask_lane2, byte_mask_lane3,
    input wire logic [31:0] mem_data_out_r,
    // Data toward the device
    output logic [31:0] mem_data_in
);
    logic [31:0] word_r = '0; // Stored word
    logic [3:0] rd_win_r = '0; // Cycles of read data still to show
    wire hit = !(rank0_select_n & rank1_select_n & rank2_select_n &
                 rank3_select_n);
    wire [2:0] code = {row_strobe_n, column_strobe_n, write_strobe_n};
    wire [3:0] mask = {byte_mask_lane3, byte_mask_lane2, byte_mask_lane1,
                       byte_mask_lane0};
    wire rd = hit && code == CODE_RD;
    // Latch only the unmasked bytes of a write
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++)
            if (hit && code == CODE_WR && !mask[i])
                word_r[8*i +: 8] <= mem_data_out_r[8*i +: 8];
    end
    // Show the word after a read; a changing pattern when released
    always @(posedge clock) begin
        rd_win_r <= {rd_win_r[2:0], rd};
        mem_data_in <= (rd || |rd_win_r) ? word_r : ~mem_data_in;
    end
    initial mem_data_in = '0;
endmodule

// ==== tb/sdpi_top_tb_top.sv ====
// Testbench of the memory pin interface: directed and random requests
`timescale 1ns/1ps
module sdpi_top_tb_top;
    import sdpi_pkg::*;
    // Design inputs
    logic clock = 0, nrst = 1, mult_3x = 0, half_width = 0, big_parts = 0;
    logic req_valid = 0;
    sdpi_req_t req = '0;
    logic [31:0] mem_data_in;
    // Design outputs
    logic req_ready, rd_valid_r, mem_clock_out_a, mem_clock_out_b;
    logic mem_clock_enable_a, mem_clock_enable_b, row_strobe_n;
    logic rank0_select_n, rank1_select_n, rank2_select_n, rank3_select_n;
    logic column_strobe_n, write_strobe_n, byte_mask_lane0, byte_mask_lane1;
    logic byte_mask_lane2, byte_mask_lane3;
    logic [13:0] mem_row_col_address;
    logic [31:0] rd_data_r, mem_data_out_r, mem_data_oe_r;
    int fail_count = 0, cmp_count = 0, n;
    // Bundled pin views
    wire [3:0] sel = {rank3_select_n, rank2_select_n, rank1_select_n,
                      rank0_select_n};
    wire [2:0] pins = {row_strobe_n, column_strobe_n, write_strobe_n};
    wire [3:0] masks = {byte_mask_lane3, byte_mask_lane2, byte_mask_lane1,
                        byte_mask_lane0};
    always #10 clock = ~clock;
    sdpi_top uut (.*);
    sdpi_mem_model mem (.*);
    // Compare one value and count it
    task automatic check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // Print the counts and the verdict, then stop
    task automatic summarize;
        $display("compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Pin code expected for each command
    function automatic logic [2:0] code_of(sdpi_cmd_t c);
        logic [2:0] t [8] = '{CODE_NOP, CODE_ACT, CODE_RD, CODE_WR,
                              CODE_PRE, CODE_REF, CODE_MRS, CODE_BST};
        return t[c];
    endfunction
    // Drive one request, wait for its take, then check the pins
    task automatic issue(input sdpi_cmd_t c, input logic [1:0] rk,
                         input logic [31:0] wd, input logic [3:0] wm);
        sdpi_req_t r;
        r = {c, rk, 14'($urandom), 14'($urandom), 4'($urandom), wd, wm};
        req <= r;
        req_valid <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (!req_ready && n < 8);
        if (!req_ready) begin fail_count++; summarize(); end
        req_valid <= 1'b0;
        #1;
        check(sel, 4'(big_parts ? r.rank_addr : ~(4'h1 << rk)));
        check(pins, code_of(c));
        if (c == SDPI_WR) begin
            check(masks, wm | (half_width ? 4'hc : 4'h0));
            check(mem_data_out_r, wd);
            check(mem_data_oe_r,
                  half_width ? 32'h0000ffff : 32'hffffffff);
        end
        @(posedge clock);
    endtask
    // Wait for the read pulse and compare its data
    task automatic wait_read(input logic [31:0] exp);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (rd_valid_r !== 1'b1 && n < 10);
        if (rd_valid_r !== 1'b1) begin fail_count++; summarize(); end
        check(rd_data_r, exp);
    endtask
    // Main sequence
    initial begin
        logic [31:0] w;
        n = $urandom(32'h9f2beb55);
        nrst <= 1'b0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        for (int c = 0; c < 8; c++)
            issue(sdpi_cmd_t'(c), 2'(c), $urandom, 4'h0);
        w = $urandom;
        issue(SDPI_WR, 2'h2, w, 4'h0);
        issue(SDPI_WR, 2'h2, ~w, 4'h5);
        issue(SDPI_RD, 2'h1, '0, 4'h0);
        wait_read({~w[31:24], w[23:16], ~w[15:8], w[7:0]});
        half_width <= 1'b1;
        issue(SDPI_WR, 2'h3, w, 4'h0);
        issue(SDPI_RD, 2'h3, '0, 4'h0);
        wait_read({16'h0, w[15:0]});
        half_width <= 1'b0;
        big_parts <= 1'b1;
        issue(SDPI_ACT, 2'h0, '0, 4'h0);
        big_parts <= 1'b0;
        repeat (400) begin
            @(posedge clock);
            req <= $bits(req)'({$urandom, $urandom, $urandom});
            req_valid <= 1'($urandom);
            if ($urandom % 50 == 0) mult_3x <= ~mult_3x;
        end
        @(posedge clock);
        req_valid <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        check(sel, SEL_IDLE);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        check(mem_clock_enable_b, 1'b1);
        summarize();
    end
endmodule
